// file: dtsl_trigger.sv
`timescale 1ns/100ps
module dtsl_trigger import dtsl_pkg::*; (
	input wire logic I_CLOCK,
	input wire logic I_RESETN,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	input wire dtsl_capture_t I_CAPTURE,
	output logic O_WB_ACK,
	output logic [31:0] O_WB_DAT,
	output logic O_TRIGGER,
	output logic O_STORE_VALID,
	output logic [15:0] O_STORE_DATA,
	output logic O_BREAK_REQ,
	output logic O_ARMED
);
	dtsl_state_t state_q, state_d;
	dtsl_setup_t setup_q, setup_d;
	dtsl_ctrl_t ctrl_q, ctrl_d;
	logic af_q, af_d;
	logic bf_q, bf_d;
	logic [3:0] count_q, count_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic trig_q, trig_d;
	logic store_q, store_d;
	logic [15:0] sdata_q, sdata_d;
	logic brk_q, brk_d;
	logic armed_q, armed_d;

	logic a_hit, b_hit, in_range, trig, event_only, begin_eff;
	logic bus_req, wr, wr_setup, wr_ctrl, store_now;
	logic [7:0] word_adr;
	dtsl_ctrl_t wctrl;
	dtsl_status_t status;

	// comparator qualification and trigger selection
	always_comb begin
		a_hit = I_CAPTURE.cmp_a_match & (~setup_q.exec_qual | I_CAPTURE.opcode_exec);
		b_hit = I_CAPTURE.cmp_b_match & (~setup_q.exec_qual | I_CAPTURE.opcode_exec);
		in_range = I_CAPTURE.access & ~I_CAPTURE.below_a & ~I_CAPTURE.above_b
			& (~setup_q.exec_qual | I_CAPTURE.opcode_exec);
		event_only = (setup_q.mode == MODE_EVENT_B) | (setup_q.mode == MODE_A_THEN_EVENT_B);
		begin_eff = setup_q.trace_begin | event_only;
		case (setup_q.mode)
			MODE_A_ONLY: trig = a_hit;
			MODE_A_OR_B: trig = a_hit | b_hit;
			// A must have hit in an earlier cycle of this run
			MODE_A_THEN_B: trig = af_q & b_hit;
			MODE_EVENT_B: trig = b_hit;
			MODE_A_THEN_EVENT_B: trig = af_q & b_hit;
			MODE_A_AND_B: trig = a_hit & b_hit;
			MODE_A_NOT_B: trig = a_hit & ~I_CAPTURE.cmp_b_match;
			MODE_INSIDE: trig = in_range;
			MODE_OUTSIDE: begin
				trig = I_CAPTURE.access & (I_CAPTURE.below_a | I_CAPTURE.above_b)
					& (~setup_q.exec_qual | I_CAPTURE.opcode_exec);
			end
			default: trig = 1'b0;
		endcase
	end

	// status image, armed bit only shows while enabled
	always_comb begin
		status.a_hit = af_q;
		status.b_hit = bf_q;
		status.armed = armed_q & ctrl_q.enable;
		status.zero = 1'b0;
		status.count = count_q;
	end

	// bus decode; writes land on the edge where the master sees ack
	always_comb begin
		bus_req = I_WB_CYC & I_WB_STB;
		word_adr = {I_WB_ADR[7:2], 2'b00};
		wr = bus_req & I_WB_WE & ack_q & I_WB_SEL[0];
		wr_setup = wr & (word_adr == ADDR_TRIG_SETUP);
		wr_ctrl = wr & (word_adr == ADDR_DEBUG_CTRL);
		wctrl = dtsl_ctrl_t'(I_WB_DAT[7:0]);
	end

	// next state of the whole block
	always_comb begin
		state_d = state_q;
		setup_d = setup_q;
		ctrl_d = ctrl_q;
		af_d = af_q;
		bf_d = bf_q;
		count_d = count_q;
		trig_d = 1'b0;
		store_d = 1'b0;
		sdata_d = sdata_q;
		brk_d = 1'b0;
		store_now = 1'b0;
		// one wait cycle before ack keeps read data registered
		ack_d = bus_req & ~ack_q;
		rdat_d = rdat_q;
		if (bus_req & ~ack_q) begin
			case (word_adr)
				ADDR_TRIG_SETUP: rdat_d = {24'h000000, setup_q};
				ADDR_RUN_STATUS: rdat_d = {24'h000000, status};
				ADDR_DEBUG_CTRL: rdat_d = {24'h000000, ctrl_q.enable, armed_q, ctrl_q[5:0]};
				default: rdat_d = 32'h00000000;
			endcase
		end
		if (state_q != ST_IDLE) begin
			if (a_hit) begin
				af_d = 1'b1;
			end
			if (b_hit) begin
				bf_d = 1'b1;
			end
			// event-only modes store one byte per event
			if (event_only) begin
				store_now = trig;
				sdata_d = store_now ? {8'h00, I_CAPTURE.data[7:0]} : sdata_q;
			end else begin
				store_now = (state_q == ST_STORE) & I_CAPTURE.access;
				sdata_d = store_now ? I_CAPTURE.data : sdata_q;
			end
			store_d = store_now;
			// count saturates at full; circular fill keeps it there
			if (store_now & (count_q != COUNT_FULL)) begin
				count_d = count_q + 4'h1;
			end
			if (!begin_eff) begin
				if (trig) begin
					trig_d = 1'b1;
					state_d = ST_IDLE;
					brk_d = ctrl_q.brk_enable;
				end
			end else begin
				if ((state_q == ST_WAIT) & trig) begin
					trig_d = 1'b1;
					state_d = event_only ? ST_WAIT : ST_STORE;
				end
				if (store_now & (count_q == COUNT_LAST)) begin
					state_d = ST_IDLE;
					brk_d = ctrl_q.brk_enable;
				end
			end
		end
		// setup is frozen for the whole run
		if (wr_setup & (state_q == ST_IDLE)) begin
			setup_d = {I_WB_DAT[7:6], 2'b00, I_WB_DAT[3:0]};
		end
		// control writes override the run sequencing above
		if (wr_ctrl) begin
			ctrl_d = wctrl;
			ctrl_d.arm = 1'b0;
			if (!wctrl.enable | !wctrl.arm) begin
				state_d = ST_IDLE;
				brk_d = 1'b0;
			end else if (state_q == ST_IDLE) begin
				state_d = begin_eff ? ST_WAIT : ST_STORE;
				af_d = 1'b0;
				bf_d = 1'b0;
				count_d = COUNT_ZERO;
			end
		end
		armed_d = (state_d != ST_IDLE);
	end

	// registers only; status has no write path at all
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESETN) begin
			state_q <= ST_IDLE;
			setup_q <= SETUP_RESET;
			ctrl_q <= CTRL_RESET;
			af_q <= 1'b0;
			bf_q <= 1'b0;
			count_q <= COUNT_ZERO;
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
			trig_q <= 1'b0;
			store_q <= 1'b0;
			sdata_q <= 16'h0000;
			brk_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			state_q <= state_d;
			setup_q <= setup_d;
			ctrl_q <= ctrl_d;
			af_q <= af_d;
			bf_q <= bf_d;
			count_q <= count_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			trig_q <= trig_d;
			store_q <= store_d;
			sdata_q <= sdata_d;
			brk_q <= brk_d;
			armed_q <= armed_d;
		end
	end

	assign O_WB_ACK = ack_q;
	assign O_WB_DAT = rdat_q;
	assign O_TRIGGER = trig_q;
	assign O_STORE_VALID = store_q;
	assign O_STORE_DATA = sdata_q;
	assign O_BREAK_REQ = brk_q;
	assign O_ARMED = armed_q;

	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESETN);

	a_setup_write_locked: assert property (
		wr_setup & armed_q |=> setup_q == $past(setup_q))
		else $error("setup changed while armed");

	a_setup_zero_bits: assert property (
		wr_setup & (I_WB_DAT[5:4] != 2'b00) |=> setup_q.zero == 2'b00)
		else $error("setup bits 5:4 not zero");

	a_exec_qualify: assert property (
		setup_q.exec_qual & ~I_CAPTURE.opcode_exec & ~wr_ctrl |=> ~O_TRIGGER)
		else $error("trigger without executed opcode");

	a_no_trigger_mode: assert property (
		setup_q.mode > MODE_OUTSIDE |=> ~O_TRIGGER & ~O_BREAK_REQ)
		else $error("trigger in reserved mode");

	a_run_start_clear: assert property (
		wr_ctrl & wctrl.enable & wctrl.arm & ~armed_q
		|=> O_ARMED & ~af_q & ~bf_q & (count_q == COUNT_ZERO))
		else $error("run start did not clear status");

	a_manual_stop: assert property (
		wr_ctrl & ~wctrl.arm |=> ~O_ARMED ##1 ~O_ARMED)
		else $error("run not stopped by software");

	a_end_trace_done: assert property (
		armed_q & ~begin_eff & trig & ~wr_ctrl
		|=> ~O_ARMED & O_TRIGGER & (O_BREAK_REQ == $past(ctrl_q.brk_enable)))
		else $error("end trace not finished on trigger");

	a_begin_full_done: assert property (
		armed_q & begin_eff & store_now & (count_q == COUNT_LAST) & ~wr_ctrl
		|=> ~O_ARMED & (count_q == COUNT_FULL) & (O_BREAK_REQ == $past(ctrl_q.brk_enable)))
		else $error("begin trace not finished on full");

	a_count_hold_idle: assert property (
		~armed_q & ~wr_ctrl |=> $stable(count_q) & $stable(af_q) & $stable(bf_q))
		else $error("status changed while idle");

	a_event_low_byte: assert property (
		armed_q & event_only & store_now |=> O_STORE_VALID & (O_STORE_DATA[15:8] == 8'h00))
		else $error("event store used high byte");
endmodule

// file: dtsl_pkg.sv
// Contract
// - setup register writable only while not armed
// - setup bits 5 and 4 read zero
// - type bit 7 qualifies matches by execution
// - bit 6 picks begin or end trace
// - event-only modes always run as begin trace
// - mode codes 0000 to 0110 select comparator combos
// - 0111 inside range, 1000 outside range
// - mode codes 1001 to 1111 never trigger
// - status bit 7 is A hit since arming
// - status bit 6 is B hit since arming
// - status bit 5 mirrors arm while enabled
// - run ends on full (begin) or trigger (end)
// - writing arm or enable zero ends run
// - valid count clears at start, 0 to 8
// - valid count holds while FIFO is read
// - run status register ignores all writes
// - event-only stores keep only the low byte
// - break on full (begin) or trigger (end)
package dtsl_pkg;
	// register byte addresses on the wishbone bus
	localparam logic [7:0] ADDR_TRIG_SETUP = 8'h00;
	localparam logic [7:0] ADDR_RUN_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DEBUG_CTRL = 8'h08;
	// values after reset and count limits
	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] COUNT_ZERO = 4'h0;
	localparam logic [3:0] COUNT_LAST = 4'h7;
	localparam logic [3:0] COUNT_FULL = 4'h8;
	// trigger mode codes
	localparam logic [3:0] MODE_A_ONLY = 4'h0;
	localparam logic [3:0] MODE_A_OR_B = 4'h1;
	localparam logic [3:0] MODE_A_THEN_B = 4'h2;
	localparam logic [3:0] MODE_EVENT_B = 4'h3;
	localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
	localparam logic [3:0] MODE_A_AND_B = 4'h5;
	localparam logic [3:0] MODE_A_NOT_B = 4'h6;
	localparam logic [3:0] MODE_INSIDE = 4'h7;
	localparam logic [3:0] MODE_OUTSIDE = 4'h8;

	typedef struct packed {
		logic exec_qual;
		logic trace_begin;
		logic [1:0] zero;
		logic [3:0] mode;
	} dtsl_setup_t;

	typedef struct packed {
		logic a_hit;
		logic b_hit;
		logic armed;
		logic zero;
		logic [3:0] count;
	} dtsl_status_t;

	typedef struct packed {
		logic enable;
		logic arm;
		logic tag_sel;
		logic brk_enable;
		logic [3:0] rw_bits;
	} dtsl_ctrl_t;

	// one bus cycle as seen by the comparators
	typedef struct packed {
		logic access;
		logic cmp_a_match;
		logic cmp_b_match;
		logic below_a;
		logic above_b;
		logic opcode_exec;
		logic [15:0] data;
	} dtsl_capture_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_STORE
	} dtsl_state_t;
endpackage

// file: dtsl_cmp_model.sv
`timescale 1ns/100ps
// comparator side: one bus cycle per request, data keeps moving when idle
module dtsl_cmp_model import dtsl_pkg::*; (
	input wire logic i_clk,
	input wire logic [2:0] i_kind,
	output dtsl_capture_t o_cap = '0
);
	logic [15:0] dat_q = 16'h5A3C;
	// kinds: 1 plain, 2 A seen, 3 B seen, 4 A executed
	always_ff @(posedge i_clk) begin
		dat_q <= dat_q + 16'h1357;
		o_cap.access <= i_kind != 3'h0;
		o_cap.cmp_a_match <= i_kind == 3'h2 || i_kind == 3'h4;
		o_cap.cmp_b_match <= i_kind == 3'h3;
		o_cap.below_a <= 1'b0;
		o_cap.above_b <= 1'b0;
		o_cap.opcode_exec <= i_kind == 3'h4;
		o_cap.data <= dat_q;
	end
endmodule

// file: dtsl_trigger_bench.sv
`timescale 1ns/100ps
module dtsl_trigger_bench import dtsl_pkg::*; ;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [2:0] kind = 3'h0;
	dtsl_capture_t cap;
	logic ack, trig, stv, brk, armed;
	logic [31:0] rdat;
	logic [15:0] sdat;
	logic [7:0] r;
	int fails = 0, checked = 0, ticks = 0, trigs = 0, brks = 0;

	dtsl_trigger dut (.I_CLOCK(clk), .I_RESETN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .I_CAPTURE(cap),
		.O_WB_ACK(ack), .O_WB_DAT(rdat), .O_TRIGGER(trig), .O_STORE_VALID(stv),
		.O_STORE_DATA(sdat), .O_BREAK_REQ(brk), .O_ARMED(armed));
	dtsl_cmp_model cmp (.i_clk(clk), .i_kind(kind), .o_cap(cap));

	initial forever #20 clk = ~clk;

	// pulse tallies and hang guard
	always @(posedge clk) begin
		ticks++;
		if (trig === 1'b1) trigs++;
		if (brk === 1'b1) brks++;
		if (ticks == 2000) begin
			fails++;
			conclude();
		end
	end

	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e, input string n);
		wb(1'b0, a, 8'h00);
		chk(n, r, e);
	endtask

	// n bus cycles of one kind, then let the run settle
	task send(input logic [2:0] k, input int n);
		repeat (n) begin
			kind <= k;
			@(posedge clk);
		end
		kind <= 3'h0;
		repeat (3) @(posedge clk);
	endtask

	task end_trace();
		int t;
		wb(1'b1, ADDR_TRIG_SETUP, 8'h80);
		wb(1'b1, ADDR_DEBUG_CTRL, 8'hC0);
		rd(ADDR_RUN_STATUS, 8'h20, "armed status");
		t = trigs;
		send(3'h1, 2);
		send(3'h2, 1);
		chk("trigger count", trigs[7:0], t[7:0]);
		send(3'h4, 1);
		chk("trigger count", trigs[7:0], t[7:0] + 8'h01);
		rd(ADDR_RUN_STATUS, 8'h84, "end status");
		rd(ADDR_RUN_STATUS, 8'h84, "held status");
	endtask

	task locked();
		int t;
		wb(1'b1, ADDR_TRIG_SETUP, 8'h09);
		wb(1'b1, ADDR_DEBUG_CTRL, 8'hC0);
		wb(1'b1, ADDR_TRIG_SETUP, 8'h00);
		rd(ADDR_TRIG_SETUP, 8'h09, "locked setup");
		t = trigs;
		send(3'h2, 1);
		send(3'h3, 1);
		chk("trigger count", trigs[7:0], t[7:0]);
		wb(1'b1, ADDR_DEBUG_CTRL, 8'h80);
		wb(1'b0, ADDR_RUN_STATUS, 8'h00);
		chk("armed bit", r & 8'h20, 8'h00);
		chk("armed pin", {7'h0, armed}, 8'h00);
	endtask

	// begin trace: B starts storage, eight words end it with a break
	task begin_trace();
		int t;
		wb(1'b1, ADDR_TRIG_SETUP, 8'h41);
		wb(1'b1, ADDR_DEBUG_CTRL, 8'hD0);
		t = trigs;
		send(3'h1, 2);
		send(3'h3, 1);
		chk("trigger count", trigs[7:0], t[7:0] + 8'h01);
		send(3'h1, 9);
		rd(ADDR_RUN_STATUS, 8'h48, "full status");
		chk("break count", brks[7:0], 8'h01);
	endtask

	// event-only B with begin bit clear: still a begin trace, eight events fill it
	task event_run();
		int t;
		wb(1'b1, ADDR_TRIG_SETUP, 8'h03);
		wb(1'b1, ADDR_DEBUG_CTRL, 8'hC0);
		t = trigs;
		send(3'h3, 1);
		chk("armed pin", {7'h0, armed}, 8'h01);
		send(3'h3, 7);
		chk("trigger count", trigs[7:0], t[7:0] + 8'h08);
		chk("store high byte", sdat[15:8], 8'h00);
		rd(ADDR_RUN_STATUS, 8'h48, "event status");
	endtask

	task conclude();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(ADDR_TRIG_SETUP, SETUP_RESET, "setup reset");
		rd(ADDR_RUN_STATUS, 8'h00, "status reset");
		wb(1'b1, ADDR_TRIG_SETUP, 8'hFF);
		rd(ADDR_TRIG_SETUP, 8'hCF, "setup zero bits");
		wb(1'b1, ADDR_RUN_STATUS, 8'hFF);
		rd(ADDR_RUN_STATUS, 8'h00, "status write");
		rd(8'h0C, 8'h00, "unmapped");
		end_trace();
		locked();
		begin_trace();
		event_run();
		conclude();
	end
endmodule
